/* design/hmi_pkg.sv */
package hmi_pkg;

  // Register and data widths.
  localparam int unsigned HMI_ADDR_W = 8;
  localparam int unsigned HMI_DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] HMI_OFS_EVENT_A = 8'h03;
  localparam logic [7:0] HMI_OFS_EVENT_B = 8'h04;
  localparam logic [7:0] HMI_OFS_MASK_A = 8'h05;
  localparam logic [7:0] HMI_OFS_MASK_B = 8'h06;
  localparam logic [7:0] HMI_OFS_STATUS_A = 8'h07;

  // Reset values.
  localparam logic [7:0] HMI_MASK_A_RESET = 8'h00;
  localparam logic [7:0] HMI_MASK_B_RESET = 8'h00;
  localparam logic [7:0] HMI_STATUS_A_RESET = 8'h00;
  localparam logic [7:0] HMI_RDATA_RESET = 8'h00;
  localparam logic [7:0] HMI_UNMAPPED_DATA = 8'h00;

  // Writable bits of the first mask and of the first event register.
  localparam logic [7:0] HMI_A_WRITABLE = 8'h7F;

  // Field positions shared by event, mask and status registers A.
  localparam int unsigned HMI_A_TEMP_C_POS = 6;
  localparam int unsigned HMI_A_TEMP_B_POS = 5;
  localparam int unsigned HMI_A_TEMP_A_POS = 4;
  localparam int unsigned HMI_A_FIVE_POS = 3;
  localparam int unsigned HMI_A_THREE_POS = 2;
  localparam int unsigned HMI_A_CORE_POS = 1;
  localparam int unsigned HMI_A_TWO_HALF_POS = 0;
  localparam int unsigned HMI_A_USED = 7;

  // Field positions shared by event and mask registers B.
  localparam int unsigned HMI_B_SECOND_POS = 7;
  localparam int unsigned HMI_B_DIODE_POS = 6;
  localparam int unsigned HMI_B_TACH_D_POS = 5;
  localparam int unsigned HMI_B_TACH_C_POS = 4;
  localparam int unsigned HMI_B_TACH_B_POS = 3;
  localparam int unsigned HMI_B_TACH_A_POS = 2;
  localparam int unsigned HMI_B_PRIMARY_POS = 1;
  localparam int unsigned HMI_B_TWELVE_POS = 0;
  localparam int unsigned HMI_B_USED = 8;

endpackage

/* design/hmi_event_bit.sv */
`timescale 1ns/1ps
// One sticky change flag: set on any change of its watched level, cleared by a write of one.
module hmi_event_bit (
  input wire logic sys_clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic clk_en, // Clock enable; all state holds while low.
  input wire logic watch_en, // Change detection is armed while high.
  input wire logic level, // Monitored condition level.
  input wire logic clear, // Write-one-to-clear strobe for this flag.
  output logic flag // Latched change flag.
);

  logic prev_ff;
  logic flag_ff;
  logic change;

  // A change is any difference from the previous sampled level while watch_en is high.
  assign change = watch_en & (level ^ prev_ff);
  assign flag = flag_ff;

  // Previous level follows the input every enabled cycle.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      prev_ff <= 1'b0;
    else if (clk_en)
      prev_ff <= level;
  end

  // A new change in the clearing cycle keeps the flag set.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      flag_ff <= 1'b0;
    else if (clk_en)
    begin
      if (change)
        flag_ff <= 1'b1;
      else if (clear)
        flag_ff <= 1'b0;
    end
  end

endmodule

/* design/hmi_top.sv */
`timescale 1ns/1ps
module hmi_top (
  input wire logic sys_clk, // System clock, 10 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic clk_en, // Clock enable; all state holds while low.
  input wire logic monitor_start, // Monitoring start control bit.
  input wire logic temp_c_beyond, // Zone 3 temperature beyond a limit.
  input wire logic temp_b_beyond, // Zone 2 temperature beyond a limit.
  input wire logic temp_a_beyond, // Zone 1 temperature beyond a limit.
  input wire logic five_volt_beyond, // 5 V input outside a limit.
  input wire logic three_volt_beyond, // 3.3 V input outside a limit.
  input wire logic core_volt_beyond, // Core input outside a limit.
  input wire logic two_half_volt_beyond, // 2.5 V input outside a limit.
  input wire logic second_sensor_fault, // Second sensor communication problem.
  input wire logic diode_fault, // Remote diode connection fault.
  input wire logic tach_d_fault, // Fan 4 stalled or slow.
  input wire logic tach_c_fault, // Fan 3 stalled or slow.
  input wire logic tach_b_fault, // Fan 2 stalled or slow.
  input wire logic tach_a_fault, // Fan 1 stalled or slow.
  input wire logic primary_sensor_fault, // Primary sensor communication problem.
  input wire logic twelve_volt_beyond, // 12 V input outside a limit.
  input wire logic [7:0] reg_addr, // Register offset.
  input wire logic reg_wr_en, // Write strobe, one cycle.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_rd_en, // Read strobe, one cycle.
  output logic [7:0] reg_rdata, // Read data, valid with reg_rd_valid.
  output logic reg_rd_valid, // Read answer strobe.
  output logic health_irq // Health-monitor interrupt request, active high.
);

  // Register contents and the read path.
  logic [7:0] health_irq_mask_a_ff;
  logic [7:0] health_irq_mask_b_ff;
  logic [7:0] health_limit_status_a_ff;
  logic [7:0] health_event_flags_a;
  logic [7:0] health_event_flags_b;
  logic [7:0] src_a;
  logic [7:0] src_b;
  logic [7:0] clr_a;
  logic [7:0] clr_b;
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;
  logic rd_valid_ff;
  logic irq_ff;
  logic nxt_irq;
  logic wr_event_a;
  logic wr_event_b;
  logic wr_mask_a;
  logic wr_mask_b;

  // Mask fields.
  logic temp_c_irq_mask;
  logic temp_b_irq_mask;
  logic temp_a_irq_mask;
  logic five_volt_irq_mask;
  logic three_volt_irq_mask;
  logic core_volt_irq_mask;
  logic two_half_volt_irq_mask;
  logic second_sensor_irq_mask;
  logic diode_connection_irq_mask;
  logic tach_d_irq_mask;
  logic tach_c_irq_mask;
  logic tach_b_irq_mask;
  logic tach_a_irq_mask;
  logic primary_sensor_irq_mask;
  logic twelve_volt_irq_mask;

  // Event flag fields.
  logic temp_c_change_flag;
  logic temp_b_change_flag;
  logic temp_a_change_flag;
  logic five_volt_change_flag;
  logic three_volt_change_flag;
  logic core_volt_change_flag;
  logic two_half_volt_change_flag;
  logic second_sensor_comm_flag;
  logic diode_connection_flag;
  logic tach_d_change_flag;
  logic tach_c_change_flag;
  logic tach_b_change_flag;
  logic tach_a_change_flag;
  logic primary_sensor_comm_flag;
  logic twelve_volt_change_flag;

  // Per-group pending terms.
  logic pend_zone;
  logic pend_volt;
  logic pend_sensor;
  logic pend_diode;
  logic pend_tach;
  logic pend_twelve;

  // Monitored levels packed at their register bit positions.
  assign src_a = {1'b0, temp_c_beyond, temp_b_beyond, temp_a_beyond,
                  five_volt_beyond, three_volt_beyond, core_volt_beyond,
                  two_half_volt_beyond};
  assign src_b = {second_sensor_fault, diode_fault, tach_d_fault, tach_c_fault,
                  tach_b_fault, tach_a_fault, primary_sensor_fault,
                  twelve_volt_beyond};

  // Write decode.
  // Writes to the status offset and to unmapped offsets decode to nothing.
  assign wr_event_a = reg_wr_en && (reg_addr == hmi_pkg::HMI_OFS_EVENT_A);
  assign wr_event_b = reg_wr_en && (reg_addr == hmi_pkg::HMI_OFS_EVENT_B);
  assign wr_mask_a = reg_wr_en && (reg_addr == hmi_pkg::HMI_OFS_MASK_A);
  assign wr_mask_b = reg_wr_en && (reg_addr == hmi_pkg::HMI_OFS_MASK_B);

  // Write-one-to-clear strobes for the event flags.
  // A clear only takes effect on an enabled cycle of the write.
  assign clr_a = wr_event_a ? (reg_wdata & hmi_pkg::HMI_A_WRITABLE) : 8'h00;
  assign clr_b = wr_event_b ? reg_wdata : 8'h00;

  // Event flag latches for group A; bit 7 is reserved and stays zero.
  // Previous levels follow the inputs while monitoring is stopped, so a source already high
  // when monitoring starts is not reported as a change; only later changes set a flag.
  assign health_event_flags_a[7] = 1'b0;
  for (genvar i = 0; i < hmi_pkg::HMI_A_USED; i++)
  begin : g_event_a
    hmi_event_bit u_bit (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .watch_en(monitor_start),
      .level(src_a[i]),
      .clear(clr_a[i]),
      .flag(health_event_flags_a[i])
    );
  end

  // Event flag latches for group B.
  for (genvar j = 0; j < hmi_pkg::HMI_B_USED; j++)
  begin : g_event_b
    hmi_event_bit u_bit (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .watch_en(monitor_start),
      .level(src_b[j]),
      .clear(clr_b[j]),
      .flag(health_event_flags_b[j])
    );
  end

  // First mask register; the reserved top bit is never stored.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      health_irq_mask_a_ff <= hmi_pkg::HMI_MASK_A_RESET;
    else if (clk_en && wr_mask_a)
      health_irq_mask_a_ff <= reg_wdata & hmi_pkg::HMI_A_WRITABLE;
  end

  // Second mask register.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      health_irq_mask_b_ff <= hmi_pkg::HMI_MASK_B_RESET;
    else if (clk_en && wr_mask_b)
      health_irq_mask_b_ff <= reg_wdata;
  end

  // Limit status follows the levels, and reads zero while monitoring is stopped.
  // The status register is read-only, so writes to its offset are ignored.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      health_limit_status_a_ff <= hmi_pkg::HMI_STATUS_A_RESET;
    else if (clk_en)
    begin
      if (!monitor_start)
        health_limit_status_a_ff <= hmi_pkg::HMI_STATUS_A_RESET;
      else
        health_limit_status_a_ff <= src_a;
    end
  end

  // Mask field names.
  // Field names keep the gating equations below readable.
  assign temp_c_irq_mask = health_irq_mask_a_ff[hmi_pkg::HMI_A_TEMP_C_POS];
  assign temp_b_irq_mask = health_irq_mask_a_ff[hmi_pkg::HMI_A_TEMP_B_POS];
  assign temp_a_irq_mask = health_irq_mask_a_ff[hmi_pkg::HMI_A_TEMP_A_POS];
  assign five_volt_irq_mask = health_irq_mask_a_ff[hmi_pkg::HMI_A_FIVE_POS];
  assign three_volt_irq_mask = health_irq_mask_a_ff[hmi_pkg::HMI_A_THREE_POS];
  assign core_volt_irq_mask = health_irq_mask_a_ff[hmi_pkg::HMI_A_CORE_POS];
  assign two_half_volt_irq_mask = health_irq_mask_a_ff[hmi_pkg::HMI_A_TWO_HALF_POS];
  assign second_sensor_irq_mask = health_irq_mask_b_ff[hmi_pkg::HMI_B_SECOND_POS];
  assign diode_connection_irq_mask = health_irq_mask_b_ff[hmi_pkg::HMI_B_DIODE_POS];
  assign tach_d_irq_mask = health_irq_mask_b_ff[hmi_pkg::HMI_B_TACH_D_POS];
  assign tach_c_irq_mask = health_irq_mask_b_ff[hmi_pkg::HMI_B_TACH_C_POS];
  assign tach_b_irq_mask = health_irq_mask_b_ff[hmi_pkg::HMI_B_TACH_B_POS];
  assign tach_a_irq_mask = health_irq_mask_b_ff[hmi_pkg::HMI_B_TACH_A_POS];
  assign primary_sensor_irq_mask = health_irq_mask_b_ff[hmi_pkg::HMI_B_PRIMARY_POS];
  assign twelve_volt_irq_mask = health_irq_mask_b_ff[hmi_pkg::HMI_B_TWELVE_POS];

  // Event flag field names.
  assign temp_c_change_flag = health_event_flags_a[hmi_pkg::HMI_A_TEMP_C_POS];
  assign temp_b_change_flag = health_event_flags_a[hmi_pkg::HMI_A_TEMP_B_POS];
  assign temp_a_change_flag = health_event_flags_a[hmi_pkg::HMI_A_TEMP_A_POS];
  assign five_volt_change_flag = health_event_flags_a[hmi_pkg::HMI_A_FIVE_POS];
  assign three_volt_change_flag = health_event_flags_a[hmi_pkg::HMI_A_THREE_POS];
  assign core_volt_change_flag = health_event_flags_a[hmi_pkg::HMI_A_CORE_POS];
  assign two_half_volt_change_flag = health_event_flags_a[hmi_pkg::HMI_A_TWO_HALF_POS];
  assign second_sensor_comm_flag = health_event_flags_b[hmi_pkg::HMI_B_SECOND_POS];
  assign diode_connection_flag = health_event_flags_b[hmi_pkg::HMI_B_DIODE_POS];
  assign tach_d_change_flag = health_event_flags_b[hmi_pkg::HMI_B_TACH_D_POS];
  assign tach_c_change_flag = health_event_flags_b[hmi_pkg::HMI_B_TACH_C_POS];
  assign tach_b_change_flag = health_event_flags_b[hmi_pkg::HMI_B_TACH_B_POS];
  assign tach_a_change_flag = health_event_flags_b[hmi_pkg::HMI_B_TACH_A_POS];
  assign primary_sensor_comm_flag = health_event_flags_b[hmi_pkg::HMI_B_PRIMARY_POS];
  assign twelve_volt_change_flag = health_event_flags_b[hmi_pkg::HMI_B_TWELVE_POS];

  // Temperature zone requests pass only where their mask bit is set.
  assign pend_zone = (temp_c_change_flag & temp_c_irq_mask)
                   | (temp_b_change_flag & temp_b_irq_mask)
                   | (temp_a_change_flag & temp_a_irq_mask);

  // Supply voltage requests.
  assign pend_volt = (five_volt_change_flag & five_volt_irq_mask)
                   | (three_volt_change_flag & three_volt_irq_mask)
                   | (core_volt_change_flag & core_volt_irq_mask)
                   | (two_half_volt_change_flag & two_half_volt_irq_mask);

  // Sensor device communication requests.
  assign pend_sensor = (second_sensor_comm_flag & second_sensor_irq_mask)
                     | (primary_sensor_comm_flag & primary_sensor_irq_mask);

  // Remote diode connection request.
  assign pend_diode = diode_connection_flag & diode_connection_irq_mask;

  // Fan tachometer requests.
  assign pend_tach = (tach_d_change_flag & tach_d_irq_mask)
                   | (tach_c_change_flag & tach_c_irq_mask)
                   | (tach_b_change_flag & tach_b_irq_mask)
                   | (tach_a_change_flag & tach_a_irq_mask);

  // Twelve volt request.
  assign pend_twelve = twelve_volt_change_flag & twelve_volt_irq_mask;

  // Any gated request raises the interrupt.
  assign nxt_irq = pend_zone | pend_volt | pend_sensor
                 | pend_diode | pend_tach | pend_twelve;

  // Interrupt output register.
  // Registering the request costs one cycle but keeps the pin free of glitches.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      irq_ff <= 1'b0;
    else if (clk_en)
      irq_ff <= nxt_irq;
  end

  // Read multiplexer; unmapped offsets answer zero.
  // A read and a write in the same cycle return the old value.
  always_comb
  begin
    case (reg_addr)
      hmi_pkg::HMI_OFS_EVENT_A: nxt_rdata = health_event_flags_a;
      hmi_pkg::HMI_OFS_EVENT_B: nxt_rdata = health_event_flags_b;
      hmi_pkg::HMI_OFS_MASK_A: nxt_rdata = health_irq_mask_a_ff;
      hmi_pkg::HMI_OFS_MASK_B: nxt_rdata = health_irq_mask_b_ff;
      hmi_pkg::HMI_OFS_STATUS_A: nxt_rdata = health_limit_status_a_ff;
      default: nxt_rdata = hmi_pkg::HMI_UNMAPPED_DATA;
    endcase
  end

  // Read data is captured on the strobe and held until the next read.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rdata_ff <= hmi_pkg::HMI_RDATA_RESET;
    else if (clk_en && reg_rd_en)
      rdata_ff <= nxt_rdata;
  end

  // Read answer strobe, one cycle after the request.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rd_valid_ff <= 1'b0;
    else if (clk_en)
      rd_valid_ff <= reg_rd_en;
  end

  // Every output is driven straight from its flip-flop.
  assign reg_rdata = rdata_ff;
  assign reg_rd_valid = rd_valid_ff;
  assign health_irq = irq_ff;

endmodule

/* tb/hmi_top_asserts.sv */
`timescale 1ns/1ps
// Checks the register port, the limit status and the interrupt of the monitor block.
module hmi_top_asserts (
  input wire logic sys_clk, // Clock.
  input wire logic reset, // Reset.
  input wire logic clk_en, // Clock enable.
  input wire logic monitor_start, // Start bit.
  input wire logic temp_c_beyond, // Level.
  input wire logic temp_b_beyond, // Level.
  input wire logic temp_a_beyond, // Level.
  input wire logic five_volt_beyond, // Level.
  input wire logic three_volt_beyond, // Level.
  input wire logic core_volt_beyond, // Level.
  input wire logic two_half_volt_beyond, // Level.
  input wire logic [7:0] reg_addr, // Offset.
  input wire logic reg_wr_en, // Write strobe.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_rd_en, // Read strobe.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic reg_rd_valid, // Read answer.
  input wire logic health_irq // Interrupt.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [7:0] mask_a_ff;
  logic [7:0] mask_b_ff;
  logic [2:0] zone_lv;
  logic [3:0] volt_lv;
  logic masks_clear;
  logic rd_sts;
  // Level groups, a status read, and whether every mask bit is off.
  assign zone_lv = {temp_c_beyond, temp_b_beyond, temp_a_beyond};
  assign volt_lv = {five_volt_beyond, three_volt_beyond, core_volt_beyond, two_half_volt_beyond};
  assign masks_clear = ~|{mask_a_ff[6:0], mask_b_ff};
  assign rd_sts = clk_en && reg_rd_en && reg_addr == 8'h07;
  // Shadow copies of both mask registers, followed from the write strobe.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mask_a_ff <= 8'h00;
      mask_b_ff <= 8'h00;
    end
    else if (clk_en && reg_wr_en && reg_addr == 8'h05)
      mask_a_ff <= reg_wdata;
    else if (clk_en && reg_wr_en && reg_addr == 8'h06)
      mask_b_ff <= reg_wdata;
  end
  property p_rd_answer;
    clk_en && reg_rd_en |=> reg_rd_valid;
  endproperty
  property p_rd_single;
    clk_en && !reg_rd_en |=> !reg_rd_valid;
  endproperty
  property p_mask_a_rd;
    clk_en && reg_rd_en && reg_addr == 8'h05 |=> reg_rdata == ($past(mask_a_ff) & 8'h7F);
  endproperty
  property p_mask_b_rd;
    clk_en && reg_rd_en && reg_addr == 8'h06 |=> reg_rdata == $past(mask_b_ff);
  endproperty
  property p_zone_sts;
    rd_sts && $past(monitor_start) && $past(!reset) |=> reg_rdata[6:4] == $past(zone_lv, 2);
  endproperty
  property p_volt_sts;
    rd_sts && $past(monitor_start) && $past(!reset) |=> reg_rdata[3:0] == $past(volt_lv, 2);
  endproperty
  property p_sts_off;
    rd_sts && $past(!monitor_start) && $past(clk_en) |=> reg_rdata == 8'h00;
  endproperty
  property p_unmapped;
    clk_en && reg_rd_en && (reg_addr < 8'h03 || reg_addr > 8'h07) |=> reg_rdata == 8'h00;
  endproperty
  property p_irq_masked;
    $past(masks_clear) |-> !health_irq;
  endproperty
  property p_freeze;
    !clk_en |=> $stable(reg_rdata) && $stable(reg_rd_valid) && $stable(health_irq);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rd_single: assert property (p_rd_single) else $error("read answer without read");
  a_mask_a_rd: assert property (p_mask_a_rd) else $error("mask A read wrong");
  a_mask_b_rd: assert property (p_mask_b_rd) else $error("mask B read wrong");
  a_zone_sts: assert property (p_zone_sts) else $error("zone status wrong");
  a_volt_sts: assert property (p_volt_sts) else $error("voltage status wrong");
  a_sts_off: assert property (p_sts_off) else $error("status not cleared");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt raised");
  a_freeze: assert property (p_freeze) else $error("outputs moved while clock enable low");
  c_irq: cover property ($rose(health_irq));
  c_sts: cover property (rd_sts ##1 reg_rdata != 8'h00);
  c_clear: cover property (reg_wr_en && reg_addr == 8'h03);
endmodule

/* tb/hmi_top_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the health monitor mask and status block.
module hmi_top_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic monitor_start = 1'b0;
  logic [6:0] lv_a = 7'h00;
  logic [7:0] lv_b = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rd_valid;
  logic health_irq;
  int fail_count = 0;
  int compares = 0;
  int i;
  // Clock with a 100 ns period.
  always #50 sys_clk = ~sys_clk;
  // The block under test; the bench drives its clock enable.
  hmi_top dut_u (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .monitor_start(monitor_start),
    .temp_c_beyond(lv_a[6]), .temp_b_beyond(lv_a[5]), .temp_a_beyond(lv_a[4]),
    .five_volt_beyond(lv_a[3]), .three_volt_beyond(lv_a[2]), .core_volt_beyond(lv_a[1]),
    .two_half_volt_beyond(lv_a[0]), .second_sensor_fault(lv_b[7]), .diode_fault(lv_b[6]),
    .tach_d_fault(lv_b[5]), .tach_c_fault(lv_b[4]), .tach_b_fault(lv_b[3]),
    .tach_a_fault(lv_b[2]), .primary_sensor_fault(lv_b[1]), .twelve_volt_beyond(lv_b[0]),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .health_irq(health_irq));
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Compares one byte-wide result.
  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One register write cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask
  // One register read cycle; the answer is awaited under a bound.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n = 0;
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    while (reg_rd_valid !== 1'b1 && n < 4)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (reg_rd_valid !== 1'b1)
    begin
      fail_count++;
      give_verdict();
    end
    else
      check_val($sformatf("register %h", a), exp, reg_rdata);
  endtask
  // Checks the interrupt two cycles after its cause has landed.
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge sys_clk);
    #1;
    check_val("health_irq", {7'h00, exp}, {7'h00, health_irq});
  endtask
  // Applies new monitored levels and lets the change detection settle.
  task automatic set_lv(input logic [6:0] a, input logic [7:0] b);
    @(posedge sys_clk);
    lv_a <= a;
    lv_b <= b;
    repeat (3) @(posedge sys_clk);
  endtask
  // Main sequence.
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h7F);
    wr(8'h06, 8'hA5);
    rd(8'h06, 8'hA5);
    wr(8'h07, 8'hFF);
    rd(8'h20, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h00);
    set_lv(7'h7F, 8'hFF);
    rd(8'h07, 8'h00);
    rd(8'h03, 8'h00);
    @(posedge sys_clk);
    monitor_start <= 1'b1;
    set_lv(7'h55, 8'hAA);
    rd(8'h07, 8'h55);
    rd(8'h03, 8'h2A);
    rd(8'h04, 8'h55);
    irq_is(1'b0);
    for (i = 0; i < 7; i++)
    begin
      wr(8'h05, 8'h01 << i);
      irq_is(((8'h2A >> i) & 8'h01) != 8'h00);
    end
    wr(8'h05, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      wr(8'h06, 8'h01 << i);
      irq_is(((8'h55 >> i) & 8'h01) != 8'h00);
    end
    wr(8'h06, 8'h00);
    wr(8'h03, 8'h0A);
    rd(8'h03, 8'h20);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h00);
    set_lv(7'h54, 8'hAB);
    rd(8'h03, 8'h21);
    rd(8'h04, 8'h01);
    wr(8'h06, 8'h01);
    irq_is(1'b1);
    wr(8'h04, 8'h01);
    irq_is(1'b0);
    @(posedge sys_clk);
    monitor_start <= 1'b0;
    rd(8'h07, 8'h00);
    wr(8'h05, 8'h7F);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'h05, 8'h7F);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(8'h05, 8'h00);
    give_verdict();
  end
endmodule

bind hmi_top hmi_top_asserts chk_u (
  .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .monitor_start(monitor_start),
  .temp_c_beyond(temp_c_beyond), .temp_b_beyond(temp_b_beyond), .temp_a_beyond(temp_a_beyond),
  .five_volt_beyond(five_volt_beyond), .three_volt_beyond(three_volt_beyond),
  .core_volt_beyond(core_volt_beyond), .two_half_volt_beyond(two_half_volt_beyond),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
  .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .health_irq(health_irq));
